// >>> rtl/multi_queue_packet_flag_logic.sv
`timescale 1ns/1ps
// Overview of operation
// - packet mode needs 36-bit ports on both sides
// - one packet counter per queue, both ports
// - partial packet reports packet not ready
// - packet mode: nothing read before complete packet
// - start then end marker completes a packet
// - last packet start read: packet ready drops
// - packet count limited only by queue depth
// - repeated start marker before end is ignored
// - repeated end marker is ignored
// - modulo bits pass through untouched
// - standard mode reads from queue on read enable or while output register is empty
// - last word propagates to output register
// - read address bit two selects null queue
// - null queue empty, last word kept, invalid
// - null queue does not affect write port
// - write queue drives discrete full flags
// - almost-full bus bit per queue
// - one device drives shared flag bus
// - write address high bits match chip id
// - direct mode: address plus strobe picks driver
// - packet select at reset chooses packet mode
// - packet mode: almost-empty bus shows ready
module multi_queue_packet_flag_logic #(
  parameter int DEPTH = 4096
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [11:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output      logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output      logic                          s_axi_wready,
  output      logic [1:0]                    s_axi_bresp,
  output      logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [11:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output      logic                          s_axi_arready,
  output      logic [31:0]                   s_axi_rdata,
  output      logic [1:0]                    s_axi_rresp,
  output      logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          write_en,
  input  wire logic                          write_queue_load,
  input  wire logic [mq_flag_pkg::WADDR_W-1:0] write_queue_addr,
  input  wire logic [mq_flag_pkg::DATA_W-1:0]  write_data,
  input  wire logic                          read_en,
  input  wire logic                          read_queue_load,
  input  wire logic [mq_flag_pkg::RADDR_W-1:0] read_queue_addr,
  output      logic [mq_flag_pkg::DATA_W-1:0]  read_data,
  output      logic                          output_valid_n,
  output      logic                          packet_ready_n,
  output      logic                          queue_full_n,
  output      logic                          queue_full_oe_n,
  output      logic                          almost_full_n,
  input  wire logic                          almost_full_bus_strobe,
  output      logic [3:0]                    almost_full_bus_n,
  output      logic                          almost_full_bus_oe_n,
  input  wire logic                          almost_empty_bus_strobe,
  output      logic [3:0]                    almost_empty_bus_n,
  output      logic                          almost_empty_bus_oe_n,
  input  wire logic                          packet_select,
  input  wire logic                          flag_bus_scheme,
  input  wire logic                          chip_id_bit0,
  input  wire logic                          chip_id_bit1,
  input  wire logic                          chip_id_bit2
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int NQ = mq_flag_pkg::NUM_QUEUES;

  function automatic logic id_match(input logic [2:0] a, input logic [2:0] b);
    id_match = (a == b);
  endfunction : id_match

  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : lane_merge

  // ========================================================================
  // straps: two flops, then caught while reset is held
  logic [4:0]          strap_meta;
  logic [4:0]          strap_sync;
  mq_flag_pkg::cfg_t   cfg;
  mq_flag_pkg::cfg_t   next_cfg;

  always_ff @(posedge aclk)
  begin
    strap_meta <= {packet_select, flag_bus_scheme, chip_id_bit2, chip_id_bit1, chip_id_bit0};
    strap_sync <= strap_meta;
  end

  // mode fixed for the whole run, so no mid-traffic mode change
  always_comb
  begin
    next_cfg = cfg;
    if (!aresetn)
      next_cfg = '{packet: strap_sync[4], polled: strap_sync[3], chip_id: strap_sync[2:0]};
  end

  always_ff @(posedge aclk)
    cfg <= next_cfg;

  // ========================================================================
  // queue storage and counters
  logic [mq_flag_pkg::DATA_W-1:0] mem [NQ][DEPTH];
  logic [AW-1:0]  wr_ptr [NQ], next_wr_ptr [NQ];
  logic [AW-1:0]  rd_ptr [NQ], next_rd_ptr [NQ];
  logic [CW-1:0]  count [NQ], next_count [NQ];
  logic [CW-1:0]  pkt_cnt [NQ], next_pkt_cnt [NQ];
  logic [NQ-1:0]  wr_in_pkt, next_wr_in_pkt;
  logic [NQ-1:0]  rd_in_pkt, next_rd_in_pkt;
  logic [NQ-1:0]  pkt_inc, pkt_dec;
  logic [1:0]     wq, next_wq;
  logic           w_sel, next_w_sel;
  logic [5:0]     rq_addr, next_rq_addr;
  logic [1:0]     rq;
  logic           rq_null, rd_sel, avail, load, wr_go;
  logic [mq_flag_pkg::DATA_W-1:0] pop_word;
  logic [15:0]    af_level, ae_level;

  assign rq       = rq_addr[1:0];
  assign rq_null  = rq_addr[mq_flag_pkg::NULL_BIT];
  assign rd_sel   = id_match(rq_addr[5:3], cfg.chip_id);
  assign wr_go    = write_en && w_sel && (count[wq] != CW'(DEPTH));
  assign pop_word = mem[rq][rd_ptr[rq]];
  // packet mode holds back words until a whole packet is counted
  assign avail    = !rq_null && rd_sel && (count[rq] != '0)
                    && (!cfg.packet || (pkt_cnt[rq] != '0));
  // prefetch into an empty output register, so a lone last word still arrives
  assign load     = avail && (!output_valid_n == 1'b0 || read_en);

  // word storage keeps all 36 bits, modulo bits included
  always_ff @(posedge aclk)
  begin
    if (wr_go)
      mem[wq][wr_ptr[wq]] <= write_data;
  end

  // marker tracking on both ports
  always_comb
  begin
    next_wq        = wq;
    next_w_sel     = w_sel;
    next_rq_addr   = rq_addr;
    next_wr_in_pkt = wr_in_pkt;
    next_rd_in_pkt = rd_in_pkt;
    pkt_inc        = '0;
    pkt_dec        = '0;
    if (write_queue_load)
    begin
      next_wq    = write_queue_addr[1:0];
      next_w_sel = id_match(write_queue_addr[4:2], cfg.chip_id);
    end
    if (read_queue_load)
      next_rq_addr = read_queue_addr;
    if (wr_go)
    begin
      // a second start inside a packet and a lone end both fall through
      if (write_data[mq_flag_pkg::START_BIT] && !wr_in_pkt[wq])
        next_wr_in_pkt[wq] = 1'b1;
      else if (write_data[mq_flag_pkg::END_BIT] && wr_in_pkt[wq])
      begin
        next_wr_in_pkt[wq] = 1'b0;
        pkt_inc[wq]        = 1'b1;
      end
    end
    if (load)
    begin
      if (pop_word[mq_flag_pkg::START_BIT] && !rd_in_pkt[rq])
        next_rd_in_pkt[rq] = 1'b1;
      else if (pop_word[mq_flag_pkg::END_BIT] && rd_in_pkt[rq])
      begin
        next_rd_in_pkt[rq] = 1'b0;
        pkt_dec[rq]        = 1'b1;
      end
    end
    for (int q = 0; q < NQ; q++)
    begin
      next_wr_ptr[q]  = wr_ptr[q] + AW'(wr_go && wq == 2'(q));
      next_rd_ptr[q]  = rd_ptr[q] + AW'(load && rq == 2'(q));
      next_count[q]   = count[q] + CW'(wr_go && wq == 2'(q)) - CW'(load && rq == 2'(q));
      // counter as wide as the depth: no cap beyond the queue itself
      next_pkt_cnt[q] = pkt_cnt[q] + CW'(pkt_inc[q]) - CW'(pkt_dec[q]);
    end
    if (!aresetn)
    begin
      next_wq        = '0;
      next_w_sel     = 1'b0;
      next_rq_addr   = '0;
      next_wr_in_pkt = '0;
      next_rd_in_pkt = '0;
      for (int q = 0; q < NQ; q++)
      begin
        next_wr_ptr[q]  = '0;
        next_rd_ptr[q]  = '0;
        next_count[q]   = '0;
        next_pkt_cnt[q] = '0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    wq        <= next_wq;
    w_sel     <= next_w_sel;
    rq_addr   <= next_rq_addr;
    wr_in_pkt <= next_wr_in_pkt;
    rd_in_pkt <= next_rd_in_pkt;
    wr_ptr    <= next_wr_ptr;
    rd_ptr    <= next_rd_ptr;
    count     <= next_count;
    pkt_cnt   <= next_pkt_cnt;
  end

  // ========================================================================
  // read port and flag outputs
  logic [mq_flag_pkg::DATA_W-1:0] next_read_data;
  logic       next_ov_n, next_pr_n, next_ff_n, next_af_n;
  logic [3:0] next_afb_n, next_aeb_n;
  logic       af_drive, next_af_drive, ae_drive, next_ae_drive;
  logic [2:0] poll_slot, next_poll_slot;

  always_comb
  begin
    next_read_data = read_data;
    next_ov_n      = output_valid_n;
    next_af_drive  = af_drive;
    next_ae_drive  = ae_drive;
    next_poll_slot = poll_slot + 3'h1;
    if (load)
    begin
      next_read_data = pop_word;
      next_ov_n      = 1'b0;
    end
    else if (read_en || rq_null)
      next_ov_n = 1'b1;
    // ready only while more than the packet under way is counted
    next_pr_n = !(cfg.packet && rd_sel && !rq_null
                  && (pkt_cnt[rq] > CW'(rd_in_pkt[rq])));
    next_ff_n = !(count[wq] == CW'(DEPTH));
    next_af_n = !(16'(count[wq]) + af_level >= 16'(DEPTH));
    for (int q = 0; q < NQ; q++)
    begin
      next_afb_n[q] = !(16'(count[q]) + af_level >= 16'(DEPTH));
      next_aeb_n[q] = cfg.packet ? !(pkt_cnt[q] != '0)
                                 : !(16'(count[q]) <= ae_level);
    end
    // polled: each chip owns one slot of eight in turn
    if (cfg.polled)
    begin
      next_af_drive = id_match(next_poll_slot, cfg.chip_id);
      next_ae_drive = id_match(next_poll_slot, cfg.chip_id);
    end
    else
    begin
      if (almost_full_bus_strobe)
        next_af_drive = id_match(write_queue_addr[4:2], cfg.chip_id);
      if (almost_empty_bus_strobe)
        next_ae_drive = id_match(read_queue_addr[5:3], cfg.chip_id);
    end
    if (!aresetn)
    begin
      next_read_data = '0;
      next_ov_n      = 1'b1;
      next_pr_n      = 1'b1;
      next_ff_n      = 1'b1;
      next_af_n      = 1'b1;
      next_afb_n     = '1;
      next_aeb_n     = '1;
      next_af_drive  = 1'b0;
      next_ae_drive  = 1'b0;
      next_poll_slot = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    read_data             <= next_read_data;
    output_valid_n        <= next_ov_n;
    packet_ready_n        <= next_pr_n;
    queue_full_n          <= next_ff_n;
    queue_full_oe_n       <= !next_w_sel;
    almost_full_n         <= next_af_n;
    almost_full_bus_n     <= next_afb_n;
    almost_empty_bus_n    <= next_aeb_n;
    af_drive              <= next_af_drive;
    ae_drive              <= next_ae_drive;
    almost_full_bus_oe_n  <= !next_af_drive;
    almost_empty_bus_oe_n <= !next_ae_drive;
    poll_slot             <= next_poll_slot;
  end

  // ========================================================================
  // register bus slave
  logic        aw_got, next_aw_got, w_got, next_w_got;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, status;
  logic [15:0] next_af_level, next_ae_level;

  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    status = '0;
    for (int q = 0; q < NQ; q++)
    begin
      status[mq_flag_pkg::ST_READY_LSB + q] = (pkt_cnt[q] != '0);
      status[mq_flag_pkg::ST_EMPTY_LSB + q] = (count[q] == '0);
      status[mq_flag_pkg::ST_FULL_LSB + q]  = (count[q] == CW'(DEPTH));
    end
  end

  // both halves of a write may come in any order; act once both are held
  always_comb
  begin
    next_aw_got   = aw_got || (s_axi_awvalid && s_axi_awready);
    next_w_got    = w_got || (s_axi_wvalid && s_axi_wready);
    next_aw_addr  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb   = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid   = s_axi_bvalid && !s_axi_bready;
    next_bresp    = s_axi_bresp;
    next_af_level = af_level;
    next_ae_level = ae_level;
    if (aw_got && w_got)
    begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = mq_flag_pkg::RESP_OKAY;
      unique case (aw_addr)
        mq_flag_pkg::OFS_AF_LEVEL: next_af_level = lane_merge(af_level, w_data, w_strb);
        mq_flag_pkg::OFS_AE_LEVEL: next_ae_level = lane_merge(ae_level, w_data, w_strb);
        mq_flag_pkg::OFS_CONFIG,
        mq_flag_pkg::OFS_STATUS:   next_bresp = mq_flag_pkg::RESP_OKAY;
        default:                   next_bresp = mq_flag_pkg::RESP_SLVERR;
      endcase
    end
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = mq_flag_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        mq_flag_pkg::OFS_CONFIG:   next_rdata = 32'({cfg.chip_id, cfg.polled, cfg.packet});
        mq_flag_pkg::OFS_AF_LEVEL: next_rdata = 32'(af_level);
        mq_flag_pkg::OFS_AE_LEVEL: next_rdata = 32'(ae_level);
        mq_flag_pkg::OFS_STATUS:   next_rdata = status;
        default:
        begin
          next_rdata = '0;
          next_rresp = mq_flag_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (!aresetn)
    begin
      next_aw_got   = 1'b0;
      next_w_got    = 1'b0;
      next_aw_addr  = '0;
      next_w_data   = '0;
      next_w_strb   = '0;
      next_bvalid   = 1'b0;
      next_bresp    = mq_flag_pkg::RESP_OKAY;
      next_rvalid   = 1'b0;
      next_rdata    = '0;
      next_rresp    = mq_flag_pkg::RESP_OKAY;
      next_af_level = mq_flag_pkg::AF_LEVEL_RST;
      next_ae_level = mq_flag_pkg::AE_LEVEL_RST;
    end
  end

  always_ff @(posedge aclk)
  begin
    aw_got       <= next_aw_got;
    w_got        <= next_w_got;
    aw_addr      <= next_aw_addr;
    w_data       <= next_w_data;
    w_strb       <= next_w_strb;
    s_axi_bvalid <= next_bvalid;
    s_axi_bresp  <= next_bresp;
    s_axi_rvalid <= next_rvalid;
    s_axi_rdata  <= next_rdata;
    s_axi_rresp  <= next_rresp;
    af_level     <= next_af_level;
    ae_level     <= next_ae_level;
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_last_start_read;
    cfg.packet && load && pop_word[mq_flag_pkg::START_BIT] && !rd_in_pkt[rq]
    && pkt_cnt[rq] == CW'(1) && pkt_inc == '0 && !read_queue_load;
  endsequence

  property p_no_word_early;
    cfg.packet && $rose(!output_valid_n) && !rq_null |-> $past(pkt_cnt[rq] != '0);
  endproperty
  a_no_word_early: assert property (p_no_word_early) else $error("word left before packet complete");

  property p_pkt_count_up;
    pkt_inc[0] && !pkt_dec[0] |=> pkt_cnt[0] == $past(pkt_cnt[0]) + CW'(1);
  endproperty
  a_pkt_count_up: assert property (p_pkt_count_up) else $error("packet count did not rise");

  property p_second_start;
    // a word carrying both markers legally closes the packet, so it is left out
    wr_go && wq == 2'h0 && write_data[mq_flag_pkg::START_BIT] && !write_data[mq_flag_pkg::END_BIT]
    && wr_in_pkt[0] |=> wr_in_pkt[0];
  endproperty
  a_second_start: assert property (p_second_start) else $error("repeated start broke packet");

  property p_second_end;
    wr_go && wq == 2'h0 && write_data[mq_flag_pkg::END_BIT] && !wr_in_pkt[0] && !pkt_dec[0]
    |=> pkt_cnt[0] == $past(pkt_cnt[0]);
  endproperty
  a_second_end: assert property (p_second_end) else $error("repeated end counted a packet");

  property p_ready_drops;
    s_last_start_read |=> ##1 packet_ready_n;
  endproperty
  a_ready_drops: assert property (p_ready_drops) else $error("ready stayed low on last packet");

  property p_modulo_pass;
    load |=> read_data[35:32] == $past(pop_word[35:32]);
  endproperty
  a_modulo_pass: assert property (p_modulo_pass) else $error("marker or modulo bits altered");

  property p_auto_fill;
    output_valid_n && avail |=> !output_valid_n;
  endproperty
  a_auto_fill: assert property (p_auto_fill) else $error("last word did not fall through");

  property p_null_invalid;
    read_queue_load && read_queue_addr[mq_flag_pkg::NULL_BIT] |=> ##1 output_valid_n && $stable(read_data);
  endproperty
  a_null_invalid: assert property (p_null_invalid) else $error("null queue left output valid");

  property p_chip_match;
    write_queue_load && !id_match(write_queue_addr[4:2], cfg.chip_id) |=> queue_full_oe_n && !wr_go;
  endproperty
  a_chip_match: assert property (p_chip_match) else $error("foreign address selected this chip");

  property p_direct_drive;
    !cfg.polled && almost_full_bus_strobe && id_match(write_queue_addr[4:2], cfg.chip_id)
    |=> !almost_full_bus_oe_n;
  endproperty
  a_direct_drive: assert property (p_direct_drive) else $error("addressed chip not driving bus");

endmodule : multi_queue_packet_flag_logic

// >>> rtl/mq_flag_pkg.sv
// ==========================================================================
// shared constants and types for the packet and flag logic
package mq_flag_pkg;

  // ========================================================================
  // data word layout
  localparam int DATA_W      = 36;
  localparam int START_BIT   = 34;
  localparam int END_BIT     = 35;
  localparam int MOD_HI_BIT  = 33;
  localparam int MOD_LO_BIT  = 32;
  localparam int NUM_QUEUES  = 4;
  localparam int QSEL_W      = 2;
  localparam int WADDR_W     = 5;
  localparam int RADDR_W     = 6;
  localparam int NULL_BIT    = 2;
  localparam int ID_W        = 3;
  localparam int MIN_PKT_LEN = 4;

  // ========================================================================
  // register map, byte addresses
  localparam logic [11:0] OFS_CONFIG   = 12'h000;
  localparam logic [11:0] OFS_AF_LEVEL = 12'h004;
  localparam logic [11:0] OFS_AE_LEVEL = 12'h008;
  localparam logic [11:0] OFS_STATUS   = 12'h00c;

  // field positions
  localparam int CFG_PKT_BIT    = 0;
  localparam int CFG_SCHEME_BIT = 1;
  localparam int CFG_ID_LSB     = 2;
  localparam int ST_READY_LSB   = 0;
  localparam int ST_EMPTY_LSB   = 4;
  localparam int ST_FULL_LSB    = 8;

  // reset values
  localparam logic [15:0] AF_LEVEL_RST = 16'h0010;
  localparam logic [15:0] AE_LEVEL_RST = 16'h0010;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // modes caught at reset
  typedef struct packed {
    logic            packet;
    logic            polled;
    logic [ID_W-1:0] chip_id;
  } cfg_t;

endpackage : mq_flag_pkg

// >>> dv/writer_model.sv
`timescale 1ns/1ps
// ==========================================================================
// write-port controller: picks a queue, then streams the words it is given, whole packets or parts of one
module writer_model (
  input  wire logic        aclk,
  output      logic        write_en,
  output      logic        write_queue_load,
  output      logic [4:0]  write_queue_addr,
  output      logic [35:0] write_data
);
  initial
  begin
    write_en = 1'b0;
    write_queue_load = 1'b0;
    write_queue_addr = 5'h00;
    write_data = 36'h0;
  end

  // queue change needs one spare edge before data may follow
  task pick(input logic [4:0] a);
    write_queue_load <= 1'b1;
    write_queue_addr <= a;
    @(posedge aclk);
    write_queue_load <= 1'b0;
    @(posedge aclk);
  endtask : pick

  // markers ride on bits 35/34 with their word; callers keep packets >= 4 words
  task send(input logic [35:0] ws [$]);
    foreach (ws[i])
    begin
      write_en <= 1'b1;
      write_data <= ws[i];
      @(posedge aclk);
    end
    write_en <= 1'b0;
    // released bus flips, so a stale word can never pass for a new one
    write_data <= ~write_data;
    @(posedge aclk);
  endtask : send
endmodule : writer_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench: register bus, packet flow, null queue, flag drivers
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic write_en, write_queue_load, read_en, read_queue_load, output_valid_n, packet_ready_n;
  logic queue_full_oe_n, almost_full_bus_strobe, almost_full_bus_oe_n, almost_empty_bus_strobe;
  logic queue_full_n, almost_full_n, almost_empty_bus_oe_n;
  logic packet_select, flag_bus_scheme, chip_id_bit0, chip_id_bit1, chip_id_bit2;
  logic [3:0]  almost_full_bus_n, almost_empty_bus_n;
  logic [4:0]  write_queue_addr;
  logic [5:0]  read_queue_addr;
  logic [35:0] write_data, read_data;
  logic [35:0] pa [$];
  logic [35:0] pb [$];
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  // straps: packet mode, direct scheme, chip id 5
  multi_queue_packet_flag_logic #(.DEPTH(16)) multi_queue_packet_flag_logic_inst (.*);
  writer_model writer_model_inst (.*);

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ========================================================================
  // shared helpers
  task chk(input string n, input logic [35:0] e, input logic [35:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", 36'(e), 36'(s_axi_rdata));
    chk("rresp", 36'(er), 36'(s_axi_rresp));
  endtask : rd

  // address and data offered together, each dropped once taken
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    while (s_axi_awvalid === 1'b1 || s_axi_wvalid === 1'b1)
    begin
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      @(posedge aclk);
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", 36'(mq_flag_pkg::RESP_OKAY), 36'(s_axi_bresp));
  endtask : wr

  // ========================================================================
  // scenarios
  task t_regs;
    rd(mq_flag_pkg::OFS_CONFIG, 32'h00000015, mq_flag_pkg::RESP_OKAY);
    wr(mq_flag_pkg::OFS_AF_LEVEL, 32'h0000000c, 4'hf);
    rd(mq_flag_pkg::OFS_AF_LEVEL, 32'h0000000c, mq_flag_pkg::RESP_OKAY);
    // lane 1 held off: only the low byte of the level may change
    wr(mq_flag_pkg::OFS_AE_LEVEL, 32'h0000ab07, 4'h1);
    rd(mq_flag_pkg::OFS_AE_LEVEL, 32'h00000007, mq_flag_pkg::RESP_OKAY);
    rd(12'h010, 32'h00000000, mq_flag_pkg::RESP_SLVERR);
  endtask : t_regs

  task t_packet;
    // modulo codes ride along; pb ends with a repeated end word as filler
    pa = '{{4'h6, 32'h11111111}, {4'h4, 32'h22222222}, {4'h0, 32'h33333333}, {4'h9, 32'h44444444}};
    pb = '{{4'h4, 32'h55555555}, {4'h0, 32'h66666666}, {4'h0, 32'h77777777}, {4'h8, 32'h88888888},
           {4'h8, 32'h99999999}};
    writer_model_inst.pick(5'h14);
    read_queue_load <= 1'b1;
    read_queue_addr <= 6'h28;
    tick(1);
    read_queue_load <= 1'b0;
    // read enable held on a partial packet must not pull words out
    read_en <= 1'b1;
    writer_model_inst.send(pa[0:2]);
    tick(4);
    chk("ov partial", 36'h1, 36'(output_valid_n));
    chk("pr partial", 36'h1, 36'(packet_ready_n));
    read_en <= 1'b0;
    writer_model_inst.send(pa[3:3]);
    for (int i = 0; i < 8 && packet_ready_n !== 1'b0; i++) tick(1);
    chk("pr packet", 36'h0, 36'(packet_ready_n));
    for (int i = 0; i < 8 && output_valid_n !== 1'b0; i++) tick(1);
    chk("word 0", pa[0], read_data);
    for (int i = 1; i < 5; i++)
    begin
      read_en <= 1'b1;
      tick(1);
      read_en <= 1'b0;
      tick(2);
      if (i < 4) chk("word", pa[i], read_data);
      if (i == 1) chk("pr reading", 36'h1, 36'(packet_ready_n));
      chk("ov", (i == 4) ? 36'h1 : 36'h0, 36'(output_valid_n));
    end
    writer_model_inst.send(pb);
    for (int i = 0; i < 8 && output_valid_n !== 1'b0; i++) tick(1);
    chk("second start", pb[0], read_data);
    // null queue: word stays put but is flagged not valid
    read_queue_load <= 1'b1;
    read_queue_addr <= 6'h2c;
    tick(1);
    read_queue_load <= 1'b0;
    tick(4);
    chk("null ov", 36'h1, 36'(output_valid_n));
    chk("null data", pb[0], read_data);
    // queue 0 now holds four words and one counted packet
    chk("ae bus", 36'he, 36'(almost_empty_bus_n));
    chk("af bus", 36'he, 36'(almost_full_bus_n));
    chk("af flag", 36'h0, 36'(almost_full_n));
    chk("full flag", 36'h1, 36'(queue_full_n));
  endtask : t_packet

  task t_flags;
    almost_full_bus_strobe <= 1'b1;
    almost_empty_bus_strobe <= 1'b1;
    tick(1);
    almost_full_bus_strobe <= 1'b0;
    almost_empty_bus_strobe <= 1'b0;
    for (int i = 0; i < 6 && almost_full_bus_oe_n !== 1'b0; i++) tick(1);
    chk("af bus oe", 36'h0, 36'(almost_full_bus_oe_n));
    chk("ae bus oe", 36'h0, 36'(almost_empty_bus_oe_n));
    chk("full oe mine", 36'h0, 36'(queue_full_oe_n));
    writer_model_inst.pick(5'h08);
    tick(2);
    chk("full oe other", 36'h1, 36'(queue_full_oe_n));
    // one packet counted in queue 0, queues 1..3 empty
    rd(mq_flag_pkg::OFS_STATUS, 32'h000000e1, mq_flag_pkg::RESP_OKAY);
  endtask : t_flags

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {packet_select, flag_bus_scheme, chip_id_bit2, chip_id_bit1, chip_id_bit0} = 5'h15;
    {read_en, read_queue_load, read_queue_addr, almost_full_bus_strobe, almost_empty_bus_strobe} = '0;
    tick(20);
    aresetn <= 1'b1;
    tick(1);
    t_regs();
    t_packet();
    t_flags();
    end_of_test();
  end
endmodule : testbench
